// >>> logic/scp_scl_counts.sv
/*
 * SCL period count registers with on/off switch, bus idle detection and
 * the SCL period timer.
 * Counts are measured in cycles of clk_i.
 * Assumes a simple synchronous register port and sampled bus lines.
 */
`timescale 1ns/100ps
`include "scp_params.svh"
module scp_scl_counts
  import scp_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [`SCP_ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [1:0] reg_be_i,
  input wire logic [`SCP_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [`SCP_DATA_W-1:0] reg_rdata_o,
  input wire scp_speed_t speed_i,
  input wire logic hs_special_i,
  input wire logic gen_req_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe_o,
  output logic bus_idle_o,
  output logic ctrl_on_o,
  output logic txq_flush_o
);
  if (CNT_W != `SCP_DATA_W) begin : g_bad_width
    $error("scp_scl_counts: CNT_W must equal the register width");
  end

  // Byte lanes merge into the stored word before the clamp, so a half
  // written alone is judged together with the other half as it stands.
  function automatic logic [CNT_W-1:0] merge(input logic [CNT_W-1:0] old,
      input logic [CNT_W-1:0] wd, input logic [1:0] be);
    merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  function automatic logic [CNT_W-1:0] clamp(input logic [CNT_W-1:0] v,
      input logic [CNT_W-1:0] min);
    clamp = (v < min) ? min : v;
  endfunction

  scp_tmr_if #(.CNT_W(CNT_W)) tif();

  logic [CNT_W-1:0] ss_hcnt_q, ss_hcnt_d, ss_lcnt_q, ss_lcnt_d;
  logic [CNT_W-1:0] fs_hcnt_q, fs_hcnt_d, fs_lcnt_q, fs_lcnt_d;
  logic on_q, on_d;
  logic flush_q, flush_d;
  logic [CNT_W-1:0] rdata_q, rdata_d;
  logic wr_ok;

  // Register group: counts lock while the controller is on.
  always_comb begin
    wr_ok = reg_wr_i && !on_q;
    ss_hcnt_d = ss_hcnt_q;
    ss_lcnt_d = ss_lcnt_q;
    fs_hcnt_d = fs_hcnt_q;
    fs_lcnt_d = fs_lcnt_q;
    on_d = on_q;
    if (wr_ok && reg_addr_i == `SCP_OFS_SS_HCNT) begin
      ss_hcnt_d = clamp(merge(ss_hcnt_q, reg_wdata_i, reg_be_i),
                        `SCP_MIN_HCNT);
    end
    if (wr_ok && reg_addr_i == `SCP_OFS_SS_LCNT) begin
      ss_lcnt_d = clamp(merge(ss_lcnt_q, reg_wdata_i, reg_be_i),
                        `SCP_MIN_LCNT);
    end
    if (wr_ok && reg_addr_i == `SCP_OFS_FS_HCNT) begin
      fs_hcnt_d = clamp(merge(fs_hcnt_q, reg_wdata_i, reg_be_i),
                        `SCP_MIN_HCNT);
    end
    if (wr_ok && reg_addr_i == `SCP_OFS_FS_LCNT) begin
      fs_lcnt_d = clamp(merge(fs_lcnt_q, reg_wdata_i, reg_be_i),
                        `SCP_MIN_LCNT);
    end
    if (reg_wr_i && reg_be_i[0] && reg_addr_i == `SCP_OFS_ON_SWITCH) begin
      on_d = reg_wdata_i[`SCP_ON_BIT];
    end
    flush_d = !on_d;
    rdata_d = '0;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `SCP_OFS_SS_HCNT: rdata_d = ss_hcnt_q;
        `SCP_OFS_SS_LCNT: rdata_d = ss_lcnt_q;
        `SCP_OFS_FS_HCNT: rdata_d = fs_hcnt_q;
        `SCP_OFS_FS_LCNT: rdata_d = fs_lcnt_q;
        `SCP_OFS_ON_SWITCH: rdata_d = CNT_W'(on_q);
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ss_hcnt_q <= `SCP_RST_SS_HCNT;
      ss_lcnt_q <= `SCP_RST_SS_LCNT;
      fs_hcnt_q <= `SCP_RST_FS_HCNT;
      fs_lcnt_q <= `SCP_RST_FS_LCNT;
      on_q <= 1'b0;
      flush_q <= 1'b1;
      rdata_q <= '0;
    end else begin
      ss_hcnt_q <= ss_hcnt_d;
      ss_lcnt_q <= ss_lcnt_d;
      fs_hcnt_q <= fs_hcnt_d;
      fs_lcnt_q <= fs_lcnt_d;
      on_q <= on_d;
      flush_q <= flush_d;
      rdata_q <= rdata_d;
    end
  end

  // Timer control group. High-speed data phases are timed elsewhere, so
  // in high speed this timer runs only for the special phases.
  logic run_q, run_d;
  logic fast_q, fast_d;

  always_comb begin
    run_d = on_q && gen_req_i &&
            (speed_i != SCP_SPEED_HIGH || hs_special_i);
    fast_d = (speed_i != SCP_SPEED_STD);
    if (!run_d) begin
      fast_d = fast_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      run_q <= 1'b0;
      fast_q <= 1'b0;
    end else begin
      run_q <= run_d;
      fast_q <= fast_d;
    end
  end

  assign tif.run = run_q;
  assign tif.high_cnt = fast_q ? fs_hcnt_q : ss_hcnt_q;
  assign tif.low_cnt = fast_q ? fs_lcnt_q : ss_lcnt_q;

  scp_scl_timer #(.CNT_W(CNT_W)) u_timer (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .tif(tif.tmr)
  );

  // Idle group: count cycles with both lines high and the timer quiet.
  logic [CNT_W-1:0] idle_cnt_q, idle_cnt_d, idle_thr;
  logic idle_q, idle_d;
  logic lines_high;

  always_comb begin
    idle_thr = ss_hcnt_q + `SCP_IDLE_MARGIN;
    lines_high = scl_i && sda_i && !tif.phase_low && !tif.phase_high;
    idle_cnt_d = idle_cnt_q;
    // A threshold lowered under a running count pulls the count down to
    // it, so the counter never runs on past the threshold and wraps.
    if (!lines_high) begin
      idle_cnt_d = '0;
    end else if (idle_cnt_q > idle_thr) begin
      idle_cnt_d = idle_thr;
    end else if (idle_cnt_q != idle_thr) begin
      idle_cnt_d = idle_cnt_q + 1'b1;
    end
    idle_d = lines_high && (idle_cnt_q == idle_thr);
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      idle_cnt_q <= '0;
      idle_q <= 1'b0;
      scl_o <= 1'b0;
    end else begin
      idle_cnt_q <= idle_cnt_d;
      idle_q <= idle_d;
      scl_o <= 1'b0;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign scl_oe_o = tif.scl_drive_low;
  assign bus_idle_o = idle_q;
  assign ctrl_on_o = on_q;
  assign txq_flush_o = flush_q;

  // Phase length helper for the checks below.
  logic [1:0] ph_prev_q;
  logic [CNT_W-1:0] len_q;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ph_prev_q <= 2'b00;
      len_q <= '0;
    end else begin
      ph_prev_q <= {tif.phase_high, tif.phase_low};
      len_q <= ({tif.phase_high, tif.phase_low} != ph_prev_q) ?
               CNT_W'(1) : len_q + 1'b1;
    end
  end

  AST_SS_HIGH: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (ph_prev_q[1] && !tif.phase_high && $past(run_q) && !fast_q)
      |-> len_q == ss_hcnt_q)
    else $error("standard high phase length wrong");

  AST_SS_LOW: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (ph_prev_q[0] && !tif.phase_low && !fast_q)
      |-> len_q == ss_lcnt_q)
    else $error("standard low phase length wrong");

  AST_FS_HIGH: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (ph_prev_q[1] && !tif.phase_high && $past(run_q) && fast_q)
      |-> len_q == fs_hcnt_q)
    else $error("fast high phase length wrong");

  AST_FS_LOW: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (ph_prev_q[0] && !tif.phase_low && fast_q)
      |-> len_q == fs_lcnt_q)
    else $error("fast low phase length wrong");

  AST_LOCKED: assert property (
    @(posedge clk_i) disable iff (srst_i)
    on_q
      |=> $stable({ss_hcnt_q, ss_lcnt_q, fs_hcnt_q, fs_lcnt_q}))
    else $error("count changed while controller on");

  AST_WR_TAKEN: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (wr_ok && reg_addr_i == `SCP_OFS_FS_HCNT && reg_be_i == 2'h3 &&
     reg_wdata_i >= `SCP_MIN_HCNT) |=> fs_hcnt_q == $past(reg_wdata_i))
    else $error("accepted count write did not land");

  AST_HCNT_MIN: assert property (
    @(posedge clk_i) disable iff (srst_i)
    ss_hcnt_q >= `SCP_MIN_HCNT &&
      fs_hcnt_q >= `SCP_MIN_HCNT)
    else $error("high count below minimum");

  AST_WR_CLAMP_H: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (wr_ok && reg_addr_i == `SCP_OFS_SS_HCNT && reg_be_i == 2'h3 &&
     reg_wdata_i < `SCP_MIN_HCNT) |=> ss_hcnt_q == `SCP_MIN_HCNT)
    else $error("small high count not clamped");

  AST_LCNT_MIN: assert property (
    @(posedge clk_i) disable iff (srst_i)
    ss_lcnt_q >= `SCP_MIN_LCNT &&
      fs_lcnt_q >= `SCP_MIN_LCNT)
    else $error("low count below minimum");

  AST_WR_CLAMP_L: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (wr_ok && reg_addr_i == `SCP_OFS_SS_LCNT && reg_be_i == 2'h3 &&
     reg_wdata_i < `SCP_MIN_LCNT) |=> ss_lcnt_q == `SCP_MIN_LCNT)
    else $error("small low count not clamped");

  AST_IDLE: assert property (
    @(posedge clk_i) disable iff (srst_i)
    $rose(bus_idle_o) |-> $past(idle_cnt_q) == $past(idle_thr)
      && $past(scl_i) && $past(sda_i))
    else $error("bus idle flagged at wrong count");

  AST_IDLE_DROP: assert property (
    @(posedge clk_i) disable iff (srst_i)
    !(scl_i && sda_i)
      |=> !bus_idle_o)
    else $error("bus idle kept with a line low");

  AST_STD_CNT: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (on_q && gen_req_i && speed_i == SCP_SPEED_STD)
      |=> tif.high_cnt == ss_hcnt_q && tif.low_cnt == ss_lcnt_q)
    else $error("standard speed not on standard counts");

  AST_FS_CNT: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (on_q && gen_req_i && speed_i == SCP_SPEED_FAST)
      |=> tif.high_cnt == fs_hcnt_q && tif.low_cnt == fs_lcnt_q)
    else $error("fast speed not on fast counts");

  AST_HS_FAST: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (on_q && gen_req_i && speed_i == SCP_SPEED_HIGH && hs_special_i)
      |=> tif.high_cnt == fs_hcnt_q && tif.low_cnt == fs_lcnt_q)
    else $error("special phase not on fast counts");

  AST_HS_REFUSE: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (speed_i == SCP_SPEED_HIGH && !hs_special_i)
      |=> !run_q)
    else $error("timer run in high speed data phase");

  AST_OFF: assert property (
    @(posedge clk_i) disable iff (srst_i)
    $fell(on_q)
      |-> txq_flush_o ##1 !run_q)
    else $error("switch off did not flush and stop");

  AST_OFF_NO_RUN: assert property (
    @(posedge clk_i) disable iff (srst_i)
    !on_q
      |=> !run_q)
    else $error("timer run while controller off");
endmodule // scp_scl_counts

// >>> logic/scp_params.svh
/*
 * Constants of the SCL period count block: register byte addresses,
 * field positions, reset values, clamp minimums and the idle margin.
 * Assumes it is included by bare name by scp_scl_counts and the bench.
 */
`ifndef SCP_PARAMS_SVH
`define SCP_PARAMS_SVH

`define SCP_ADDR_W 32
`define SCP_DATA_W 16
`define SCP_OFS_SS_HCNT 32'h50001314
`define SCP_OFS_SS_LCNT 32'h50001318
`define SCP_OFS_FS_HCNT 32'h5000131c
`define SCP_OFS_FS_LCNT 32'h50001320
`define SCP_OFS_ON_SWITCH 32'h5000136c
`define SCP_ON_BIT 0
`define SCP_RST_SS_HCNT 16'h0048
`define SCP_RST_SS_LCNT 16'h004f
`define SCP_RST_FS_HCNT 16'h0008
`define SCP_RST_FS_LCNT 16'h0017
`define SCP_MIN_HCNT 16'h0006
`define SCP_MIN_LCNT 16'h0008
`define SCP_IDLE_MARGIN 16'h000a
`define SCP_CLK_PERIOD_NS 40

`endif

// >>> logic/scp_pkg.sv
/*
 * Types of the SCL period count block.
 * Assumes scp_params.svh is on the include path.
 */
package scp_pkg;
  typedef enum logic [1:0] {
    SCP_SPEED_STD = 2'b01,
    SCP_SPEED_FAST = 2'b10,
    SCP_SPEED_HIGH = 2'b11
  } scp_speed_t;

  typedef enum logic [1:0] {
    SCP_TMR_IDLE = 2'b00,
    SCP_TMR_LOW = 2'b01,
    SCP_TMR_HIGH = 2'b10
  } scp_tmr_state_t;
endpackage

// >>> logic/scp_tmr_if.sv
/*
 * Carrier between the count registers and the SCL period timer.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
interface scp_tmr_if #(parameter int CNT_W = 16);
  logic run;
  logic [CNT_W-1:0] high_cnt;
  logic [CNT_W-1:0] low_cnt;
  logic phase_high;
  logic phase_low;
  logic scl_drive_low;

  modport ctrl(output run, output high_cnt, output low_cnt,
               input phase_high, input phase_low, input scl_drive_low);
  modport tmr(input run, input high_cnt, input low_cnt,
              output phase_high, output phase_low, output scl_drive_low);
endinterface

// >>> logic/scp_scl_timer.sv
/*
 * SCL period timer: drives SCL low for the low count and releases it for
 * the high count, reloading a down-counter at each SCL edge.
 * Assumes the counts are held steady while run is high.
 */
`timescale 1ns/100ps
module scp_scl_timer
  import scp_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic clk_i,
  input wire logic srst_i,
  scp_tmr_if.tmr tif
);
  scp_tmr_state_t state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic drv_q, drv_d;

  // A low phase of N counts lasts exactly N clock cycles, a high phase N unless run drops first: load N-1, leave at 0.
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    unique case (state_q)
      SCP_TMR_IDLE: begin
        if (tif.run) begin
          state_d = SCP_TMR_LOW;
          cnt_d = tif.low_cnt - 1'b1;
        end
      end
      SCP_TMR_LOW: begin
        if (cnt_q == '0) begin
          if (tif.run) begin
            state_d = SCP_TMR_HIGH;
            cnt_d = tif.high_cnt - 1'b1;
          end else begin
            state_d = SCP_TMR_IDLE;
          end
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      SCP_TMR_HIGH: begin
        if (!tif.run) begin
          state_d = SCP_TMR_IDLE;
        end else if (cnt_q == '0) begin
          state_d = SCP_TMR_LOW;
          cnt_d = tif.low_cnt - 1'b1;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default: begin
        state_d = SCP_TMR_IDLE;
      end
    endcase
    drv_d = (state_d == SCP_TMR_LOW);
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_q <= SCP_TMR_IDLE;
      cnt_q <= '0;
      drv_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      drv_q <= drv_d;
    end
  end

  assign tif.phase_high = (state_q == SCP_TMR_HIGH);
  assign tif.phase_low = (state_q == SCP_TMR_LOW);
  assign tif.scl_drive_low = drv_q;
endmodule // scp_scl_timer

// >>> bench/scp_bus_peer.sv
/* Other devices on the two-wire bus: pull-ups and a peer that holds SDA.
   Assumes scl_oe_i high means the block pulls SCL to scl_lvl_i. */
`timescale 1ns/100ps
module scp_bus_peer (
  input wire logic scl_oe_i,
  input wire logic scl_lvl_i,
  input wire logic sda_hold_i,
  output logic scl_line_o,
  output logic sda_line_o
);
  // Released lines rise to the pull-up level.
  assign scl_line_o = scl_oe_i ? scl_lvl_i : 1'b1;
  assign sda_line_o = ~sda_hold_i;
endmodule // scp_bus_peer

// >>> bench/tb.sv
/* Bench of the SCL period count block: register tasks and test sequences.
   Assumes the design files and the bus peer are compiled first. */
`timescale 1ns/100ps
`include "scp_params.svh"
module tb
  import scp_pkg::*;
;
  logic clk_i, srst_i, reg_wr_i, reg_rd_i, hs_special_i, gen_req_i;
  logic sda_hold, scl_line, sda_line, scl_o, scl_oe_o, bus_idle_o;
  logic ctrl_on_o, txq_flush_o;
  logic [31:0] reg_addr_i;
  logic [1:0] reg_be_i;
  logic [15:0] reg_wdata_i, reg_rdata_o;
  scp_speed_t speed_i;
  int err_total, cmp_count, cyc;
  logic [31:0] adr[4] = '{`SCP_OFS_SS_HCNT, `SCP_OFS_SS_LCNT,
                          `SCP_OFS_FS_HCNT, `SCP_OFS_FS_LCNT};
  logic [15:0] rstv[4] = '{`SCP_RST_SS_HCNT, `SCP_RST_SS_LCNT,
                           `SCP_RST_FS_HCNT, `SCP_RST_FS_LCNT};
  logic [15:0] prog[4] = '{16'h0006, 16'h0008, 16'h0009, 16'h010a};
  scp_speed_t spd[3] = '{SCP_SPEED_STD, SCP_SPEED_FAST, SCP_SPEED_HIGH};

  scp_scl_counts #(.CNT_W(16)) dut (.clk_i(clk_i), .srst_i(srst_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_be_i(reg_be_i),
    .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .speed_i(speed_i),
    .hs_special_i(hs_special_i), .gen_req_i(gen_req_i), .scl_i(scl_line),
    .sda_i(sda_line), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
    .bus_idle_o(bus_idle_o), .ctrl_on_o(ctrl_on_o),
    .txq_flush_o(txq_flush_o));
  scp_bus_peer peer (.scl_oe_i(scl_oe_o), .scl_lvl_i(scl_o),
    .sda_hold_i(sda_hold), .scl_line_o(scl_line), .sda_line_o(sda_line));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_i);
      #1;
    end
  endtask

  task automatic check(input string nm, input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [1:0] be,
                    input logic [15:0] d);
    reg_addr_i = a;
    reg_be_i = be;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    tick(1);
    reg_wr_i = 1'b0;
    tick(1);
  endtask

  // Read data stands for the one cycle after the strobe is taken.
  task automatic rd(input logic [31:0] a, input logic [15:0] exp);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    tick(1);
    reg_rd_i = 1'b0;
    check("read data", reg_rdata_o, exp);
    tick(1);
    check("read data idle", reg_rdata_o, 16'h0000);
  endtask

  task automatic flags(input logic on);
    check("on switch", {15'h0, ctrl_on_o}, {15'h0, on});
    check("tx flush", {15'h0, txq_flush_o}, {15'h0, ~on});
  endtask

  // Measures the first low and high phases of the generated SCL.
  task automatic scl_period(input logic [15:0] lo, hi);
    int n;
    n = 0;
    while (scl_oe_o !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    check("scl line low", {15'h0, scl_line}, 16'h0000);
    n = 0;
    while (scl_oe_o === 1'b1 && n < 1000) begin
      tick(1);
      n++;
    end
    check("scl low cycles", n[15:0], lo);
    n = 0;
    while (scl_oe_o === 1'b0 && n < 1000) begin
      tick(1);
      n++;
    end
    check("scl high cycles", n[15:0], hi);
  endtask

  task automatic quiet();
    int n;
    n = 0;
    repeat (30) begin
      tick(1);
      if (scl_oe_o !== 1'b0) n++;
    end
    check("refused clock", n[15:0], 16'h0000);
  endtask

  initial begin
    int n;
    srst_i = 1'b1;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 32'h0;
    reg_be_i = 2'h0;
    reg_wdata_i = 16'h0;
    speed_i = SCP_SPEED_STD;
    hs_special_i = 1'b0;
    gen_req_i = 1'b0;
    sda_hold = 1'b0;
    tick(20);
    srst_i = 1'b0;
    for (int i = 0; i < 4; i++) rd(adr[i], rstv[i]);
    rd(32'h50001324, 16'h0000);
    flags(1'b0);
    $display("test reset values done");
    wr(adr[0], 2'h3, 16'h0005);
    wr(adr[1], 2'h3, 16'h0007);
    wr(adr[2], 2'h3, 16'h0009);
    wr(adr[3], 2'h1, 16'h000a);
    rd(adr[3], 16'h000a);
    wr(adr[3], 2'h2, 16'h0100);
    for (int i = 0; i < 4; i++) rd(adr[i], prog[i]);
    $display("test clamp done");
    wr(`SCP_OFS_ON_SWITCH, 2'h3, 16'h0001);
    tick(1);
    flags(1'b1);
    for (int i = 0; i < 4; i++) wr(adr[i], 2'h3, 16'hffff);
    for (int i = 0; i < 4; i++) rd(adr[i], prog[i]);
    $display("test lock done");
    for (int i = 0; i < 3; i++) begin
      speed_i = spd[i];
      hs_special_i = (i == 2);
      gen_req_i = 1'b1;
      scl_period(prog[i == 0 ? 1 : 3],
                 prog[i == 0 ? 0 : 2]);
      gen_req_i = 1'b0;
      tick(300);
    end
    gen_req_i = 1'b1;
    hs_special_i = 1'b0;
    quiet();
    gen_req_i = 1'b0;
    speed_i = SCP_SPEED_STD;
    $display("test scl timing done");
    sda_hold = 1'b1;
    tick(3);
    sda_hold = 1'b0;
    n = 0;
    while (bus_idle_o !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    check("idle delay", n[15:0],
          prog[0] + `SCP_IDLE_MARGIN + 16'h0001);
    sda_hold = 1'b1;
    tick(2);
    check("idle drop", {15'h0, bus_idle_o}, 16'h0000);
    sda_hold = 1'b0;
    $display("test idle done");
    wr(`SCP_OFS_ON_SWITCH, 2'h3, 16'h0000);
    tick(1);
    flags(1'b0);
    wr(adr[0], 2'h3, 16'h0000);
    rd(adr[0], 16'h0006);
    gen_req_i = 1'b1;
    quiet();
    $display("test switch off done");
    end_sim();
  end
endmodule // tb
